// ---- shared/cfg_pkg.sv ----
/*
 * constants for the configuration memory readout block: special function
 * addresses, configuration byte indices, field positions, reset values and
 * flash partition sizes. assumes an 8-bit special function register bus.
 */
package cfg_pkg;
    localparam logic [7:0] SFR_CONFIG_BYTE_INDEX = 8'h93;
    localparam logic [7:0] SFR_CONFIG_BYTE_VALUE = 8'h94;

    localparam int CFG_BYTES = 128;
    localparam int CFG_IDX_W = 7;
    localparam logic [6:0] IDX_PORTS_BROWNOUT = 7'h7E;
    localparam logic [6:0] IDX_FLASH_SECURITY = 7'h7F;

    // programming-time code window for configuration bytes
    localparam logic [15:0] CFG_CODE_BASE = 16'h8000;
    localparam logic [15:0] CFG_CODE_LAST = 16'h807F;

    // flash_security_partition_config fields
    localparam int BIT_PROGRAM_ACCESS_ALLOW = 7;
    localparam int BIT_PROGRAM_FLASH_LOCK = 6;
    localparam int BIT_RESET_SECTOR_LOCK = 5;
    localparam int BIT_BOOT_ROM_ENABLE = 4;
    localparam int BIT_WATCHDOG_RESET_SELECT = 3;
    localparam int POS_DATA_FLASH_SIZE = 0;

    // ports_brownout_config fields
    localparam int POS_DIGITAL_BROWNOUT_LEVEL = 6;
    localparam int POS_ANALOG_BROWNOUT_LEVEL = 4;
    localparam int BIT_ANALOG_BROWNOUT_DISABLE = 3;
    localparam int BIT_DIGITAL_BROWNOUT_DISABLE = 2;
    localparam int BIT_PORT_ZERO_GPIO_ENABLE = 1;
    localparam int BIT_PORTS_TWO_THREE_GPIO_ENABLE = 0;

    // values held until the load after reset completes
    localparam logic [7:0] FLASH_SECURITY_RESET = 8'hFF;
    localparam logic [7:0] PORTS_BROWNOUT_RESET = 8'hFF;

    // flash sizes in bytes
    localparam int FLASH_ADDR_W = 17;
    localparam logic [16:0] FLASH_PRESENT_BYTES = 17'h08000;
    localparam logic [16:0] RESET_SECTOR_BYTES = 17'h01000;

    // brownout thresholds in millivolts
    localparam logic [12:0] BROWNOUT_MV_00 = 13'd4500;
    localparam logic [12:0] BROWNOUT_MV_01 = 13'd4200;
    localparam logic [12:0] BROWNOUT_MV_10 = 13'd2700;
    localparam logic [12:0] BROWNOUT_MV_11 = 13'd2500;

    typedef enum logic [0:0] {ST_LOAD, ST_RUN} load_state_t;
endpackage

// ---- core/hw_config_memory_readout.sv ----
/*
 * configuration memory readout: a 128-byte configuration flash written only
 * in programming mode, read at run time through an index/value register pair
 * on the special function bus, and two hardware configuration bytes decoded
 * into flash protection, partition, watchdog, brownout and port controls.
 * assumes a synchronous bus, one access per cycle, and a programmer that
 * fills the array before the run-time reset is released.
 */
`timescale 1ns/1ps
`default_nettype none
module hw_config_memory_readout (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic prog_mode,
    input wire logic prog_we,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] prog_wdata,
    input wire logic [15:0] code_addr,
    output logic code_config_blocked,
    input wire logic flash_wr_req,
    input wire logic [16:0] flash_wr_addr,
    output logic flash_wr_grant,
    output logic ext_flash_access_ok,
    output logic [16:0] data_flash_bytes,
    output logic [16:0] program_flash_bytes,
    output logic boot_rom_enable,
    input wire logic watchdog_expire,
    output logic watchdog_reset_req,
    output logic watchdog_irq_req,
    output logic [12:0] digital_brownout_mv,
    output logic [12:0] analog_brownout_mv,
    input wire logic digital_brownout_raw,
    input wire logic analog_brownout_raw,
    output logic brownout_reset_req,
    output logic port_zero_gpio_enable,
    output logic ports_two_three_gpio_enable,
    output logic p3_strobes_external
);
    function automatic logic [12:0] level_mv(input logic [1:0] code);
        case (code)
            2'b00: level_mv = cfg_pkg::BROWNOUT_MV_00;
            2'b01: level_mv = cfg_pkg::BROWNOUT_MV_01;
            2'b10: level_mv = cfg_pkg::BROWNOUT_MV_10;
            default: level_mv = cfg_pkg::BROWNOUT_MV_11;
        endcase
    endfunction

    function automatic logic [16:0] data_size(input logic [2:0] code);
        case (code)
            3'b001: data_size = 17'h08000;
            3'b010: data_size = 17'h04000;
            3'b011: data_size = 17'h02000;
            3'b100: data_size = 17'h01000;
            3'b101: data_size = 17'h00800;
            3'b110: data_size = 17'h00400;
            default: data_size = 17'h00000;
        endcase
    endfunction

    // nonvolatile array: deliberately not reset, it survives run-time resets
    logic [7:0] cfg_mem [cfg_pkg::CFG_BYTES];

    logic [6:0] index_r, index_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic hit_r, hit_nxt;
    logic [7:0] fsec_r, fsec_nxt;
    logic [7:0] pbo_r, pbo_nxt;
    cfg_pkg::load_state_t state_r, state_nxt;
    logic wdt_rst_r, wdt_rst_nxt;
    logic wdt_irq_r, wdt_irq_nxt;
    logic bo_r, bo_nxt;
    logic prog_in_window;
    logic [16:0] want_data;
    logic [16:0] prog_bytes;
    logic sector_lock_all;

    assign prog_in_window = (prog_addr >= cfg_pkg::CFG_CODE_BASE)
        && (prog_addr <= cfg_pkg::CFG_CODE_LAST);

    // only the programming path writes the array
    always_ff @(posedge clock) begin
        if (prog_mode && prog_we && prog_in_window) begin
            cfg_mem[prog_addr[6:0]] <= prog_wdata;
        end
    end

    always_comb begin
        index_nxt = index_r;
        rdata_nxt = 8'h00;
        hit_nxt = 1'b0;
        if (sfr_wr && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_INDEX) begin
            index_nxt = sfr_wdata[6:0];
        end
        if (sfr_rd && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_INDEX) begin
            rdata_nxt = {1'b0, index_r};
            hit_nxt = 1'b1;
        end else if (sfr_rd && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_VALUE) begin
            rdata_nxt = cfg_mem[index_r];
            hit_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            index_r <= 7'h00;
            rdata_r <= 8'h00;
            hit_r <= 1'b0;
        end else begin
            index_r <= index_nxt;
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign sfr_rdata = rdata_r;
    assign sfr_hit = hit_r;

    // hardware bytes are captured once, one cycle after reset release
    always_comb begin
        state_nxt = state_r;
        fsec_nxt = fsec_r;
        pbo_nxt = pbo_r;
        case (state_r)
            cfg_pkg::ST_LOAD: begin
                fsec_nxt = cfg_mem[cfg_pkg::IDX_FLASH_SECURITY];
                pbo_nxt = cfg_mem[cfg_pkg::IDX_PORTS_BROWNOUT];
                state_nxt = cfg_pkg::ST_RUN;
            end
            cfg_pkg::ST_RUN: begin
                state_nxt = cfg_pkg::ST_RUN;
            end
            default: begin
                state_nxt = cfg_pkg::ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= cfg_pkg::ST_LOAD;
            fsec_r <= cfg_pkg::FLASH_SECURITY_RESET;
            pbo_r <= cfg_pkg::PORTS_BROWNOUT_RESET;
        end else begin
            state_r <= state_nxt;
            fsec_r <= fsec_nxt;
            pbo_r <= pbo_nxt;
        end
    end

    // code fetches in the configuration window never see its contents outside programming mode
    assign code_config_blocked = !prog_mode && (code_addr >= cfg_pkg::CFG_CODE_BASE)
        && (code_addr <= cfg_pkg::CFG_CODE_LAST);

    assign want_data = data_size(fsec_r[cfg_pkg::POS_DATA_FLASH_SIZE +: 3]);
    assign data_flash_bytes = (want_data > cfg_pkg::FLASH_PRESENT_BYTES)
        ? cfg_pkg::FLASH_PRESENT_BYTES : want_data;
    assign prog_bytes = cfg_pkg::FLASH_PRESENT_BYTES - data_flash_bytes;
    assign program_flash_bytes = prog_bytes;
    assign sector_lock_all = prog_bytes <= cfg_pkg::RESET_SECTOR_BYTES;

    assign ext_flash_access_ok = fsec_r[cfg_pkg::BIT_PROGRAM_ACCESS_ALLOW];
    assign boot_rom_enable = fsec_r[cfg_pkg::BIT_BOOT_ROM_ENABLE];

    // writes into the data partition are never locked by these bits
    always_comb begin
        flash_wr_grant = flash_wr_req;
        if (flash_wr_addr < prog_bytes) begin
            if (fsec_r[cfg_pkg::BIT_PROGRAM_FLASH_LOCK]) begin
                flash_wr_grant = 1'b0;
            end
            if (fsec_r[cfg_pkg::BIT_RESET_SECTOR_LOCK]
                && (flash_wr_addr < cfg_pkg::RESET_SECTOR_BYTES || sector_lock_all)) begin
                flash_wr_grant = 1'b0;
            end
        end
    end

    always_comb begin
        wdt_rst_nxt = watchdog_expire && fsec_r[cfg_pkg::BIT_WATCHDOG_RESET_SELECT];
        wdt_irq_nxt = watchdog_expire && !fsec_r[cfg_pkg::BIT_WATCHDOG_RESET_SELECT];
        bo_nxt = (digital_brownout_raw && !pbo_r[cfg_pkg::BIT_DIGITAL_BROWNOUT_DISABLE])
            || (analog_brownout_raw && !pbo_r[cfg_pkg::BIT_ANALOG_BROWNOUT_DISABLE]);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wdt_rst_r <= 1'b0;
            wdt_irq_r <= 1'b0;
            bo_r <= 1'b0;
        end else begin
            wdt_rst_r <= wdt_rst_nxt;
            wdt_irq_r <= wdt_irq_nxt;
            bo_r <= bo_nxt;
        end
    end

    assign watchdog_reset_req = wdt_rst_r;
    assign watchdog_irq_req = wdt_irq_r;
    assign brownout_reset_req = bo_r;

    assign digital_brownout_mv = level_mv(pbo_r[cfg_pkg::POS_DIGITAL_BROWNOUT_LEVEL +: 2]);
    assign analog_brownout_mv = level_mv(pbo_r[cfg_pkg::POS_ANALOG_BROWNOUT_LEVEL +: 2]);
    assign port_zero_gpio_enable = pbo_r[cfg_pkg::BIT_PORT_ZERO_GPIO_ENABLE];
    assign ports_two_three_gpio_enable = pbo_r[cfg_pkg::BIT_PORTS_TWO_THREE_GPIO_ENABLE];
    // either external mode turns port 3 pins 6 and 7 into write/read strobes
    assign p3_strobes_external = !port_zero_gpio_enable || !ports_two_three_gpio_enable;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_value_read_data: assert property (
        sfr_rd && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_VALUE
        |=> sfr_hit && sfr_rdata == cfg_mem[$past(index_r)])
        else $error("value register returned wrong byte");
    a_index_next_read: assert property (
        sfr_wr && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_INDEX
        ##1 sfr_rd && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_VALUE
        |=> sfr_rdata == cfg_mem[$past(sfr_wdata[6:0], 2)])
        else $error("new index not used on next read");
    a_index_range_kept: assert property (
        sfr_wr && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_INDEX |=> index_r == $past(sfr_wdata[6:0]))
        else $error("index register did not take written value");
    a_hw_bytes_stable: assert property (
        state_r == cfg_pkg::ST_RUN |=> $stable(fsec_r) && $stable(pbo_r))
        else $error("hardware configuration changed after load");
    a_program_lock_write: assert property (
        fsec_r[cfg_pkg::BIT_PROGRAM_FLASH_LOCK] && flash_wr_addr < prog_bytes |-> !flash_wr_grant)
        else $error("write granted into locked program flash");
    a_sector_lock_write: assert property (
        fsec_r[cfg_pkg::BIT_RESET_SECTOR_LOCK] && flash_wr_addr < cfg_pkg::RESET_SECTOR_BYTES
        && flash_wr_addr < prog_bytes |-> !flash_wr_grant)
        else $error("write granted into locked reset sector");
    a_watchdog_action: assert property (
        watchdog_expire |=> watchdog_irq_req != watchdog_reset_req
        && watchdog_reset_req == $past(fsec_r[cfg_pkg::BIT_WATCHDOG_RESET_SELECT]))
        else $error("watchdog action does not follow select bit");
    a_brownout_disable: assert property (
        pbo_r[cfg_pkg::BIT_DIGITAL_BROWNOUT_DISABLE] && pbo_r[cfg_pkg::BIT_ANALOG_BROWNOUT_DISABLE]
        && $stable(pbo_r) |=> !brownout_reset_req)
        else $error("brownout raised while detection disabled");
    a_partition_total: assert property (
        data_flash_bytes + program_flash_bytes == cfg_pkg::FLASH_PRESENT_BYTES
        && data_flash_bytes <= cfg_pkg::FLASH_PRESENT_BYTES)
        else $error("flash partition does not cover the part");
    a_code_window_blocked: assert property (
        !prog_mode && code_addr[15:7] == 9'h100 |-> code_config_blocked)
        else $error("code read of configuration window not blocked");
    a_code_window_open: assert property (
        prog_mode || code_addr[15:7] != 9'h100 |-> !code_config_blocked)
        else $error("code read outside window blocked");
    a_unmapped_read_quiet: assert property (
        sfr_rd && sfr_addr != cfg_pkg::SFR_CONFIG_BYTE_INDEX
        && sfr_addr != cfg_pkg::SFR_CONFIG_BYTE_VALUE |=> !sfr_hit && sfr_rdata == 8'h00)
        else $error("unmapped read answered");
    a_hit_one_cycle: assert property (
        !sfr_rd |=> !sfr_hit)
        else $error("hit without a read");
    a_index_read_back: assert property (
        sfr_rd && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_INDEX
        |=> sfr_hit && sfr_rdata == {1'b0, $past(index_r)})
        else $error("index register read back wrong");
    a_array_read_only: assert property (
        !prog_mode && !(sfr_wr && sfr_addr == cfg_pkg::SFR_CONFIG_BYTE_INDEX)
        |=> $stable(cfg_mem[index_r]))
        else $error("configuration byte changed outside programming");
    a_watchdog_idle: assert property (
        !watchdog_expire |=> !watchdog_reset_req && !watchdog_irq_req)
        else $error("watchdog action without expiry");
    a_load_after_release: assert property (
        state_r == cfg_pkg::ST_LOAD |=> state_r == cfg_pkg::ST_RUN
        && fsec_r == $past(cfg_mem[cfg_pkg::IDX_FLASH_SECURITY])
        && pbo_r == $past(cfg_mem[cfg_pkg::IDX_PORTS_BROWNOUT]))
        else $error("hardware bytes not taken after reset");
    a_no_data_flash: assert property (
        fsec_r[cfg_pkg::POS_DATA_FLASH_SIZE +: 3] == 3'b111
        |-> data_flash_bytes == 17'h00000
        && program_flash_bytes == cfg_pkg::FLASH_PRESENT_BYTES)
        else $error("size code 111 left data flash");
    a_largest_data_flash: assert property (
        fsec_r[cfg_pkg::POS_DATA_FLASH_SIZE +: 3] == 3'b001
        |-> data_flash_bytes == 17'h08000 && program_flash_bytes == 17'h00000)
        else $error("size code 001 not decoded as 32k");
    a_data_write_open: assert property (
        flash_wr_req && flash_wr_addr >= prog_bytes |-> flash_wr_grant)
        else $error("write into data flash refused");
    a_open_write_granted: assert property (
        flash_wr_req && !fsec_r[cfg_pkg::BIT_PROGRAM_FLASH_LOCK] && !sector_lock_all
        && flash_wr_addr >= cfg_pkg::RESET_SECTOR_BYTES |-> flash_wr_grant)
        else $error("unlocked write refused");
    a_no_request_no_grant: assert property (
        !flash_wr_req |-> !flash_wr_grant)
        else $error("grant without request");
    a_digital_level_map: assert property (
        pbo_r[cfg_pkg::POS_DIGITAL_BROWNOUT_LEVEL +: 2] == 2'b00
        |-> digital_brownout_mv == cfg_pkg::BROWNOUT_MV_00)
        else $error("digital level 00 not decoded");
    a_analog_level_map: assert property (
        pbo_r[cfg_pkg::POS_ANALOG_BROWNOUT_LEVEL +: 2] == 2'b11
        |-> analog_brownout_mv == cfg_pkg::BROWNOUT_MV_11)
        else $error("analog level 11 not decoded");
    a_analog_detect_live: assert property (
        analog_brownout_raw && !pbo_r[cfg_pkg::BIT_ANALOG_BROWNOUT_DISABLE]
        |=> brownout_reset_req)
        else $error("enabled analog brownout ignored");
    a_digital_detect_live: assert property (
        digital_brownout_raw && !pbo_r[cfg_pkg::BIT_DIGITAL_BROWNOUT_DISABLE]
        |=> brownout_reset_req)
        else $error("enabled digital brownout ignored");
    a_port_zero_mode: assert property (
        !pbo_r[cfg_pkg::BIT_PORT_ZERO_GPIO_ENABLE]
        |-> !port_zero_gpio_enable && p3_strobes_external)
        else $error("port zero not in external memory mode");
    a_ports_two_three_mode: assert property (
        !pbo_r[cfg_pkg::BIT_PORTS_TWO_THREE_GPIO_ENABLE]
        |-> !ports_two_three_gpio_enable && p3_strobes_external)
        else $error("ports two and three not in external memory mode");
endmodule
`default_nettype wire

// ---- tb/cfg_programmer.sv ----
/* device programmer model: loads user data and the two hardware bytes
   through the programming port. assumes the device is held in reset. */
`timescale 1ns/1ps
`default_nettype none
module cfg_programmer (
    input wire logic clock,
    input wire logic start,
    input wire logic [7:0] sec_byte,
    input wire logic [7:0] port_byte,
    output logic prog_mode,
    output logic prog_we,
    output logic [15:0] prog_addr,
    output logic [7:0] prog_wdata,
    output logic done
);
    int n;
    initial begin
        prog_mode = 1'b0;
        prog_we = 1'b0;
        prog_addr = 16'h0000;
        prog_wdata = 8'h00;
        done = 1'b0;
        forever begin
            @(posedge clock);
            if (start) begin
                done <= 1'b0;
                prog_mode <= 1'b1;
                for (n = 0; n < 112; n++) begin
                    prog_we <= 1'b1;
                    // user bytes stay inside their window so hardware bytes are never hit
                    prog_addr <= (n < 110) ? 16'h8002 + 16'(n) : 16'h807E + 16'(n - 110);
                    prog_wdata <= (n < 110) ? 8'(n + 16) : ((n == 110) ? port_byte : sec_byte);
                    @(posedge clock);
                end
                prog_we <= 1'b0;
                prog_mode <= 1'b0;
                prog_addr <= ~prog_addr;
                prog_wdata <= ~prog_wdata;
                done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/hw_config_memory_readout_tb.sv ----
/* bench for the configuration readout: programs the memory through the
   programmer model, then checks decoding and register reads. */
`timescale 1ns/1ps
`default_nettype none
module hw_config_memory_readout_tb;
    logic clock, rst_b, sfr_wr, sfr_rd, prog_mode, prog_we, flash_wr_req, start, done, sfr_hit;
    logic watchdog_expire, digital_brownout_raw, analog_brownout_raw, code_config_blocked;
    logic flash_wr_grant, ext_flash_access_ok, boot_rom_enable, watchdog_reset_req;
    logic watchdog_irq_req, brownout_reset_req, port_zero_gpio_enable;
    logic ports_two_three_gpio_enable, p3_strobes_external;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, prog_wdata, sec_byte, port_byte;
    logic [15:0] prog_addr, code_addr;
    logic [16:0] flash_wr_addr, data_flash_bytes, program_flash_bytes;
    logic [12:0] digital_brownout_mv, analog_brownout_mv;
    int err_total = 0;
    int tests_run = 0;
    hw_config_memory_readout dut_u (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .prog_mode(prog_mode), .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .code_addr(code_addr), .code_config_blocked(code_config_blocked),
        .flash_wr_req(flash_wr_req), .flash_wr_addr(flash_wr_addr),
        .flash_wr_grant(flash_wr_grant), .ext_flash_access_ok(ext_flash_access_ok),
        .data_flash_bytes(data_flash_bytes), .program_flash_bytes(program_flash_bytes),
        .boot_rom_enable(boot_rom_enable), .watchdog_expire(watchdog_expire),
        .watchdog_reset_req(watchdog_reset_req), .watchdog_irq_req(watchdog_irq_req),
        .digital_brownout_mv(digital_brownout_mv), .analog_brownout_mv(analog_brownout_mv),
        .digital_brownout_raw(digital_brownout_raw), .analog_brownout_raw(analog_brownout_raw),
        .brownout_reset_req(brownout_reset_req), .port_zero_gpio_enable(port_zero_gpio_enable),
        .ports_two_three_gpio_enable(ports_two_three_gpio_enable),
        .p3_strobes_external(p3_strobes_external));
    cfg_programmer prog_u (.clock(clock), .start(start), .sec_byte(sec_byte),
        .port_byte(port_byte), .prog_mode(prog_mode), .prog_we(prog_we),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata), .done(done));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // the array is not reset, so it is filled while reset is held
    task automatic load(input logic [7:0] s, input logic [7:0] p);
        int k;
        @(posedge clock);
        rst_b <= 1'b0;
        sec_byte <= s;
        port_byte <= p;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        k = 0;
        do @(posedge clock); while (!done && ++k < 300);
        if (!done) begin
            err_total++;
            results();
        end
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr <= w;
        sfr_rd <= !w;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        #1;
    endtask
    // index write and value read on consecutive edges
    task automatic pick(input logic [7:0] ix, input logic [7:0] ex);
        @(posedge clock);
        sfr_wr <= 1'b1;
        sfr_addr <= 8'h93;
        sfr_wdata <= ix;
        @(posedge clock);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        sfr_addr <= 8'h94;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1 chk({sfr_hit, sfr_rdata}, {1'b1, ex});
    endtask
    task automatic grant(input logic [16:0] a, input logic exp);
        @(posedge clock);
        flash_wr_req <= 1'b1;
        flash_wr_addr <= a;
        #1 chk(flash_wr_grant, exp);
    endtask
    task automatic pulse_wd(input logic r);
        @(posedge clock);
        watchdog_expire <= 1'b1;
        @(posedge clock);
        watchdog_expire <= 1'b0;
        #1 chk({watchdog_reset_req, watchdog_irq_req}, {r, !r});
        @(posedge clock);
        #1 chk({watchdog_reset_req, watchdog_irq_req}, 2'h0);
    endtask
    task automatic brown(input logic [1:0] raw, input logic exp);
        @(posedge clock);
        {digital_brownout_raw, analog_brownout_raw} <= raw;
        @(posedge clock);
        {digital_brownout_raw, analog_brownout_raw} <= 2'h0;
        #1 chk(brownout_reset_req, exp);
        repeat (2) @(posedge clock);
    endtask
    task automatic sizes();
        int i;
        logic [16:0] dsz;
        logic [12:0] mv[4] = '{13'h1194, 13'h1068, 13'h0A8C, 13'h09C4};
        for (i = 0; i < 8; i++) begin
            load({5'h17, 3'(i)}, {2'(i), 2'(3 - i), 4'hF});
            dsz = (i == 0 || i == 7) ? 17'h00000 : 17'h10000 >> i;
            chk(data_flash_bytes, dsz);
            chk(program_flash_bytes, 17'h08000 - dsz);
            chk(digital_brownout_mv, mv[i % 4]);
            chk(analog_brownout_mv, mv[3 - i % 4]);
        end
    endtask
    task automatic cfg_a();
        logic [7:0] ix[4] = '{8'h82, 8'h6F, 8'h7E, 8'h7F};
        logic [7:0] ex[4] = '{8'h10, 8'h7D, 8'h0C, 8'hBC};
        load(8'hBC, 8'h0C);
        chk(ext_flash_access_ok, 1'b1);
        chk(boot_rom_enable, 1'b1);
        chk({port_zero_gpio_enable, ports_two_three_gpio_enable, p3_strobes_external}, 3'h1);
        grant(17'h00800, 1'b0);
        grant(17'h01000, 1'b1);
        pulse_wd(1'b1);
        brown(2'h3, 1'b0);
        foreach (ix[j]) begin
            sfr(1'b1, 8'h93, ix[j]);
            sfr(1'b0, 8'h94, 8'h00);
            chk({sfr_hit, sfr_rdata}, {1'b1, ex[j]});
            pick(ix[j], ex[j]);
        end
        sfr(1'b0, 8'h93, 8'h00);
        chk({sfr_hit, sfr_rdata}, 9'h17F);
        sfr(1'b1, 8'h94, 8'hAA);
        sfr(1'b0, 8'h94, 8'h00);
        chk({sfr_hit, sfr_rdata}, 9'h1BC);
        sfr(1'b0, 8'h95, 8'h00);
        chk({sfr_hit, sfr_rdata}, 9'h000);
        @(posedge clock);
        code_addr <= 16'h807E;
        #1 chk(code_config_blocked, 1'b1);
        @(posedge clock);
        code_addr <= 16'h8080;
        #1 chk(code_config_blocked, 1'b0);
    endtask
    task automatic cfg_b();
        load(8'h64, 8'hF3);
        chk(ext_flash_access_ok, 1'b0);
        chk(boot_rom_enable, 1'b0);
        chk({port_zero_gpio_enable, ports_two_three_gpio_enable, p3_strobes_external}, 3'h6);
        grant(17'h02000, 1'b0);
        grant(17'h07800, 1'b1);
        pulse_wd(1'b0);
        brown(2'h2, 1'b1);
        brown(2'h1, 1'b1);
    endtask
    initial begin
        {rst_b, sfr_wr, sfr_rd, prog_mode, flash_wr_req, start, watchdog_expire} = 7'h00;
        {digital_brownout_raw, analog_brownout_raw, sfr_addr, sfr_wdata} = 18'h00000;
        {sec_byte, port_byte, code_addr, flash_wr_addr} = 49'h0;
        repeat (3) @(posedge clock);
        sizes();
        cfg_a();
        cfg_b();
        results();
    end
endmodule
`default_nettype wire
